// ==== src/pin_cfg.svh ====
// constants for the pin 10 to 15 configuration block
//
// Behaviour
// - passive-to-active edge wakes an input pin unless disable set
// - polarity sets input sense and output supply
// - pin 11 function: blink od, in, seq, reg
// - pin 10 function: power-enable in, in, od, reg
// - pin 10 polarity applies to power-enable input
// - pin 13 function: feedback pp, in, feedback od, reg
// - pin 12 function: fault, in, monitor, reg
// - pin 15 function: blink od, in, clock, reg od
// - pin 14 function: blink od, in, data, reg
// - mode bit sets debounce or driven level
`ifndef PIN_CFG_SVH
`define PIN_CFG_SVH
`define ADDR_PIN10_11      8'h1a
`define ADDR_PIN12_13      8'h1b
`define ADDR_PIN14_15      8'h1c
`define CFG_RESET          8'h00
`define FIELD_FUNC_LO      1:0
`define FIELD_POL_LO       2
`define FIELD_WAKE_LO      3
`define FIELD_FUNC_HI      5:4
`define FIELD_POL_HI       6
`define FIELD_WAKE_HI      7
`define FUNC_00            2'h0
`define FUNC_01            2'h1
`define FUNC_10            2'h2
`define FUNC_11            2'h3
`endif

// ==== src/pin_config_top.sv ====
// configuration and pin muxing for general pins 10 to 15
`include "pin_cfg.svh"
module pin_config_top
  import pin_pkg::*;
#(
  parameter int PIN_COUNT = 6
)
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  // control interface register port
  input  wire logic                 reg_write,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  // debounce and level bits, pins 10 to 15
  input  wire logic [PIN_COUNT-1:0] level_debounce,
  // internal function sources
  input  wire logic                 sequencer_level,
  input  wire logic                 blink_level,
  input  wire logic                 feedback_state_signal,
  input  wire logic                 supply_fault_indicator,
  input  wire logic                 vsys_monitor_state,
  input  wire logic                 two_wire_data_out,
  input  wire logic                 two_wire_data_oe,
  input  wire logic                 two_wire_clock_out,
  input  wire logic                 two_wire_clock_oe,
  // pins
  input  wire logic [PIN_COUNT-1:0] pin_in,
  output logic      [PIN_COUNT-1:0] pin_out,
  output logic      [PIN_COUNT-1:0] pin_oe,
  output logic      [PIN_COUNT-1:0] pin_supply_two,
  // status
  output logic      [PIN_COUNT-1:0] general_input,
  output logic      [PIN_COUNT-1:0] debounce_enable,
  output logic      [PIN_COUNT-1:0] wake_event,
  output logic                      secondary_power_enable,
  output logic                      two_wire_enable,
  output logic                      two_wire_data_in,
  output logic                      two_wire_clock_in
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [7:0] pin10_11_config_reg;
  logic [7:0] pin10_11_config_next;
  logic [7:0] pin12_13_config_reg;
  logic [7:0] pin12_13_config_next;
  logic [7:0] pin14_15_config_reg;
  logic [7:0] pin14_15_config_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // write decode and read mux
  always_comb
  begin
    pin10_11_config_next = pin10_11_config_reg;
    pin12_13_config_next = pin12_13_config_reg;
    pin14_15_config_next = pin14_15_config_reg;
    if (reg_write && reg_addr == `ADDR_PIN10_11)
      pin10_11_config_next = reg_wdata;
    else if (reg_write && reg_addr == `ADDR_PIN12_13)
      pin12_13_config_next = reg_wdata;
    else if (reg_write && reg_addr == `ADDR_PIN14_15)
      pin14_15_config_next = reg_wdata;
    if (reg_addr == `ADDR_PIN10_11)
      rdata_next = pin10_11_config_reg;
    else if (reg_addr == `ADDR_PIN12_13)
      rdata_next = pin12_13_config_reg;
    else if (reg_addr == `ADDR_PIN14_15)
      rdata_next = pin14_15_config_reg;
    else
      rdata_next = 8'h00;
  end

  // register storage
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pin10_11_config_reg <= `CFG_RESET;
      pin12_13_config_reg <= `CFG_RESET;
      pin14_15_config_reg <= `CFG_RESET;
      rdata_reg           <= 8'h00;
    end
    else
    begin
      pin10_11_config_reg <= pin10_11_config_next;
      pin12_13_config_reg <= pin12_13_config_next;
      pin14_15_config_reg <= pin14_15_config_next;
      rdata_reg           <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // field unpacking, index 0 is pin 10
  logic [1:0] pin_function [PIN_COUNT];
  logic       pin_polarity [PIN_COUNT];
  logic       wake_disable [PIN_COUNT];

  // pin pairs: upper nibble is the odd pin
  always_comb
  begin
    pin_function[0] = pin10_11_config_reg[`FIELD_FUNC_LO];
    pin_function[1] = pin10_11_config_reg[`FIELD_FUNC_HI];
    pin_function[2] = pin12_13_config_reg[`FIELD_FUNC_LO];
    pin_function[3] = pin12_13_config_reg[`FIELD_FUNC_HI];
    pin_function[4] = pin14_15_config_reg[`FIELD_FUNC_LO];
    pin_function[5] = pin14_15_config_reg[`FIELD_FUNC_HI];
    pin_polarity[0] = pin10_11_config_reg[`FIELD_POL_LO];
    pin_polarity[1] = pin10_11_config_reg[`FIELD_POL_HI];
    pin_polarity[2] = pin12_13_config_reg[`FIELD_POL_LO];
    pin_polarity[3] = pin12_13_config_reg[`FIELD_POL_HI];
    pin_polarity[4] = pin14_15_config_reg[`FIELD_POL_LO];
    pin_polarity[5] = pin14_15_config_reg[`FIELD_POL_HI];
    wake_disable[0] = pin10_11_config_reg[`FIELD_WAKE_LO];
    wake_disable[1] = pin10_11_config_reg[`FIELD_WAKE_HI];
    wake_disable[2] = pin12_13_config_reg[`FIELD_WAKE_LO];
    wake_disable[3] = pin12_13_config_reg[`FIELD_WAKE_HI];
    wake_disable[4] = pin14_15_config_reg[`FIELD_WAKE_LO];
    wake_disable[5] = pin14_15_config_reg[`FIELD_WAKE_HI];
  end

  ////////////////////////////////////////////////////////////////////////////
  // function selection per pin
  drive_mode_type  drive_mode [PIN_COUNT];
  logic            drive_level [PIN_COUNT];
  logic [PIN_COUNT-1:0] is_input;
  logic            data_mode;

  // data mode on pin 14 enables the clock role of pin 15 when pin 15 selects it
  assign data_mode = (pin_function[4] == `FUNC_10);

  always_comb
  begin
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      drive_mode[i]  = drive_off_type;
      drive_level[i] = 1'b0;
      is_input[i]    = (pin_function[i] == `FUNC_01);
    end
    // pin 10
    case (pin_function[0])
      `FUNC_00: is_input[0] = 1'b1;
      `FUNC_10:
      begin
        drive_mode[0]  = drive_od_type;
        drive_level[0] = level_debounce[0];
      end
      `FUNC_11:
      begin
        drive_mode[0]  = drive_pp_type;
        drive_level[0] = level_debounce[0];
      end
      default: drive_mode[0] = drive_off_type;
    endcase
    // pin 11
    case (pin_function[1])
      `FUNC_00:
      begin
        drive_mode[1]  = drive_od_type;
        drive_level[1] = blink_level ^ level_debounce[1];
      end
      `FUNC_10:
      begin
        drive_mode[1]  = drive_pp_type;
        drive_level[1] = sequencer_level;
      end
      `FUNC_11:
      begin
        drive_mode[1]  = drive_pp_type;
        drive_level[1] = level_debounce[1];
      end
      default: drive_mode[1] = drive_off_type;
    endcase
    // pin 12
    case (pin_function[2])
      `FUNC_00:
      begin
        drive_mode[2]  = drive_pp_type;
        drive_level[2] = supply_fault_indicator ~^ level_debounce[2];
      end
      `FUNC_10:
      begin
        drive_mode[2]  = drive_pp_type;
        drive_level[2] = vsys_monitor_state ~^ level_debounce[2];
      end
      `FUNC_11:
      begin
        drive_mode[2]  = drive_pp_type;
        drive_level[2] = level_debounce[2];
      end
      default: drive_mode[2] = drive_off_type;
    endcase
    // pin 13
    case (pin_function[3])
      `FUNC_00:
      begin
        drive_mode[3]  = drive_pp_type;
        drive_level[3] = feedback_state_signal ~^ level_debounce[3];
      end
      `FUNC_10:
      begin
        drive_mode[3]  = drive_od_type;
        drive_level[3] = feedback_state_signal ~^ level_debounce[3];
      end
      `FUNC_11:
      begin
        drive_mode[3]  = drive_pp_type;
        drive_level[3] = level_debounce[3];
      end
      default: drive_mode[3] = drive_off_type;
    endcase
    // pin 14
    case (pin_function[4])
      `FUNC_00:
      begin
        drive_mode[4]  = drive_od_type;
        drive_level[4] = blink_level ^ level_debounce[4];
      end
      `FUNC_10:
      begin
        drive_mode[4]  = two_wire_data_oe ? drive_od_type : drive_off_type;
        drive_level[4] = two_wire_data_out;
      end
      `FUNC_11:
      begin
        drive_mode[4]  = drive_pp_type;
        drive_level[4] = level_debounce[4];
      end
      default: drive_mode[4] = drive_off_type;
    endcase
    // pin 15, clock role only when pin 14 selects data
    case (pin_function[5])
      `FUNC_00:
      begin
        drive_mode[5]  = drive_od_type;
        drive_level[5] = blink_level ^ level_debounce[5];
      end
      `FUNC_10:
      begin
        drive_mode[5]  = (data_mode && two_wire_clock_oe) ? drive_od_type : drive_off_type;
        drive_level[5] = two_wire_clock_out;
      end
      `FUNC_11:
      begin
        drive_mode[5]  = drive_od_type;
        drive_level[5] = level_debounce[5];
      end
      default: drive_mode[5] = drive_off_type;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers, open drain only drives low
  logic [PIN_COUNT-1:0] out_next;
  logic [PIN_COUNT-1:0] oe_next;
  logic [PIN_COUNT-1:0] out_reg;
  logic [PIN_COUNT-1:0] oe_reg;
  logic [PIN_COUNT-1:0] supply_reg;
  logic [PIN_COUNT-1:0] deb_reg;
  logic [PIN_COUNT-1:0] active_level;

  generate
    for (genvar g = 0; g < PIN_COUNT; g++)
    begin : g_pin
      always_comb
      begin
        out_next[g] = (drive_mode[g] == drive_pp_type) ? drive_level[g] : 1'b0;
        oe_next[g]  = (drive_mode[g] == drive_pp_type) ||
                      ((drive_mode[g] == drive_od_type) && !drive_level[g]);
      end

      pin_wake_detect u_wake
      (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .pin_level    (pin_in[g]),
        .polarity     (pin_polarity[g]),
        .is_input     (is_input[g]),
        .wake_disable (wake_disable[g]),
        .active       (active_level[g]),
        .wake         (wake_event[g])
      );
    end
  endgenerate

  // drive, supply and debounce registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      out_reg    <= '0;
      oe_reg     <= '0;
      supply_reg <= '0;
      deb_reg    <= '0;
    end
    else
    begin
      out_reg <= out_next;
      oe_reg  <= oe_next;
      for (int i = 0; i < PIN_COUNT; i++)
      begin
        supply_reg[i] <= pin_polarity[i];
        deb_reg[i]    <= is_input[i] && level_debounce[i];
      end
    end
  end

  assign pin_out         = out_reg;
  assign pin_oe          = oe_reg;
  assign pin_supply_two  = supply_reg;
  assign debounce_enable = deb_reg;
  assign general_input   = active_level;

  ////////////////////////////////////////////////////////////////////////////
  // power-enable and two-wire status
  logic pwr_reg;
  logic tw_en_reg;
  logic tw_d_reg;
  logic tw_c_reg;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pwr_reg   <= 1'b0;
      tw_en_reg <= 1'b0;
      tw_d_reg  <= 1'b1;
      tw_c_reg  <= 1'b1;
    end
    else
    begin
      pwr_reg   <= (pin_function[0] == `FUNC_00) && (pin_in[0] == pin_polarity[0]);
      tw_en_reg <= data_mode && (pin_function[5] == `FUNC_10);
      tw_d_reg  <= pin_in[4];
      tw_c_reg  <= pin_in[5];
    end
  end

  assign secondary_power_enable = pwr_reg;
  assign two_wire_enable        = tw_en_reg;
  assign two_wire_data_in       = tw_d_reg;
  assign two_wire_clock_in      = tw_c_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_power_enable;
    @(posedge sys_clk) disable iff (reset)
      ##1 secondary_power_enable == $past(pin_function[0] == `FUNC_00 && pin_in[0] == pin_polarity[0]);
  endproperty
  a_power_enable: assert property (p_power_enable) else $error("power enable mismatch");

  // write to the middle register, then the same address held one cycle
  sequence s_write_then_hold;
    (reg_write && reg_addr == `ADDR_PIN12_13) ##1 (reg_addr == $past(reg_addr));
  endsequence

  property p_readback;
    @(posedge sys_clk) disable iff (reset)
      s_write_then_hold |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_pin11_input;
    @(posedge sys_clk) disable iff (reset)
      (pin_function[1] == `FUNC_01) |=> !pin_oe[1];
  endproperty
  a_pin11_input: assert property (p_pin11_input) else $error("pin 11 drives as input");

  property p_pin12_reg;
    @(posedge sys_clk) disable iff (reset)
      (pin_function[2] == `FUNC_11) |=> pin_oe[2] && pin_out[2] == $past(level_debounce[2]);
  endproperty
  a_pin12_reg: assert property (p_pin12_reg) else $error("pin 12 register drive wrong");

  property p_pin13_od;
    @(posedge sys_clk) disable iff (reset)
      (pin_function[3] == `FUNC_10) |=> !pin_out[3];
  endproperty
  a_pin13_od: assert property (p_pin13_od) else $error("pin 13 open drain drives high");

  property p_pin10_od;
    @(posedge sys_clk) disable iff (reset)
      (pin_function[0] == `FUNC_10) |=> pin_oe[0] == !$past(level_debounce[0]);
  endproperty
  a_pin10_od: assert property (p_pin10_od) else $error("pin 10 open drain wrong");

  property p_pin15_clock;
    @(posedge sys_clk) disable iff (reset)
      (pin_function[5] == `FUNC_10 && !data_mode) |=> !pin_oe[5];
  endproperty
  a_pin15_clock: assert property (p_pin15_clock) else $error("pin 15 clock without data mode");

  property p_pin14_data;
    @(posedge sys_clk) disable iff (reset)
      (data_mode && !two_wire_data_oe) |=> !pin_oe[4];
  endproperty
  a_pin14_data: assert property (p_pin14_data) else $error("pin 14 data driven unasked");

  property p_supply;
    @(posedge sys_clk) disable iff (reset)
      1'b1 |=> pin_supply_two[3] == $past(pin_polarity[3]);
  endproperty
  a_supply: assert property (p_supply) else $error("supply select wrong");

  property p_debounce;
    @(posedge sys_clk) disable iff (reset)
      (pin_function[5] == `FUNC_11) |=> !debounce_enable[5];
  endproperty
  a_debounce: assert property (p_debounce) else $error("debounce on output");
endmodule : pin_config_top

// ==== src/pin_pkg.sv ====
// types shared by the pin configuration block
package pin_pkg;
  typedef enum logic [2:0]
  {
    drive_off_type  = 3'h1,
    drive_pp_type   = 3'h2,
    drive_od_type   = 3'h4
  } drive_mode_type;
endpackage : pin_pkg

// ==== src/pin_wake_detect.sv ====
// passive-to-active edge detector for one pin
module pin_wake_detect
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // pin and settings
  input  wire logic pin_level,
  input  wire logic polarity,
  input  wire logic is_input,
  input  wire logic wake_disable,
  // result
  output logic      active,
  output logic      wake
);
  logic active_reg;
  logic active_next;
  logic wake_reg;
  logic wake_next;

  // active level per polarity, edge raises wake
  always_comb
  begin
    active_next = (pin_level == polarity);
    wake_next   = is_input && active_next && !active_reg && !wake_disable;
  end

  // registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      active_reg <= 1'b0;
      wake_reg   <= 1'b0;
    end
    else
    begin
      active_reg <= active_next;
      wake_reg   <= wake_next;
    end
  end

  assign active = active_reg;
  assign wake   = wake_reg;

  property p_wake_edge;
    @(posedge sys_clk) disable iff (reset)
      wake |-> $past(!wake_disable) && $past(is_input) && $past(pin_level == polarity);
  endproperty
  a_wake_edge: assert property (p_wake_edge) else $error("wake without enabled edge");
endmodule : pin_wake_detect

// ==== test/gpio_pin_config_10_to_15_bench.sv ====
// self-checking bench for the pin 10 to 15 configuration block
`define CHK(nm, ex, gt) \
  begin \
    samples_checked++; \
    if ((gt) !== (ex)) \
    begin \
      errors++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module gpio_pin_config_10_to_15_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk        = 1'b0;
  logic       reset          = 1'b1;
  logic       reg_write      = 1'b0;
  logic [7:0] reg_addr       = 8'h00;
  logic [7:0] reg_wdata      = 8'h00;
  logic [7:0] reg_rdata;
  logic [5:0] level_debounce = 6'h00;
  logic [8:0] src            = 9'h000;
  logic [5:0] ext_drive      = 6'h00;
  logic [5:0] ext_level      = 6'h00;
  logic [5:0] pin_in, pin_out, pin_oe, pin_supply_two, general_input, debounce_enable, wake_event;
  logic       spe, twe, tdin, tcin;
  int         errors          = 0;
  int         samples_checked = 0;
  int         seed            = 32'h5c448d5f;
  int         cfg [3]         = '{0, 0, 0};
  bit   [5:0] prev;
  logic [5:0] e_sup, e_gin, e_gin_m, e_deb, e_wake, e_oe, e_out;
  logic [7:0] e_rdata;
  logic       e_spe, e_twe, e_tdin, e_tcin;

  ////////////////////////////////////////////////////////////////////////////////
  // clock, design and far side
  always #20 sys_clk = ~sys_clk;

  pin_config_top #(.PIN_COUNT(6)) DUT
  (
    .sys_clk(sys_clk), .reset(reset), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .level_debounce(level_debounce),
    .sequencer_level(src[0]), .blink_level(src[1]), .feedback_state_signal(src[2]),
    .supply_fault_indicator(src[3]), .vsys_monitor_state(src[4]), .two_wire_data_out(src[5]),
    .two_wire_data_oe(src[6]), .two_wire_clock_out(src[7]), .two_wire_clock_oe(src[8]),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_supply_two(pin_supply_two),
    .general_input(general_input), .debounce_enable(debounce_enable), .wake_event(wake_event),
    .secondary_power_enable(spe), .two_wire_enable(twe), .two_wire_data_in(tdin),
    .two_wire_clock_in(tcin)
  );

  pin_world_model #(.PIN_COUNT(6)) world
  (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext_drive), .ext_level(ext_level),
    .pin_level(pin_in)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // reference model: expected outputs after the coming edge
  task automatic predict();
    int f;
    int d;
    bit p;
    bit a;
    bit m;
    bit l;
    {e_sup, e_gin, e_gin_m, e_deb, e_wake, e_oe, e_out} = '0;
    for (int i = 0; i < 6; i++)
    begin
      f = (cfg[i / 2] >> (i % 2 * 4)) & 3;
      p = cfg[i / 2][i % 2 * 4 + 2];
      a = (pin_in[i] === p);
      m = level_debounce[i];
      e_sup[i] = p;
      if (f == 1 || (i == 0 && f == 0))
      begin
        e_gin_m[i] = 1'b1;
        e_gin[i] = a;
        e_deb[i] = m;
        e_wake[i] = a && !prev[i] && !cfg[i / 2][i % 2 * 4 + 3];
      end
      else
      begin
        // drive kind: 0 off, 1 push-pull, 2 open drain
        d = 1;
        l = m;
        if (f == 0 && (i == 1 || i >= 4))
        begin
          d = 2;
          l = src[1] ^ m;
        end
        else if (f == 0)
          l = ((i == 2) ? src[3] : src[2]) ~^ m;
        else if (f == 2 && i == 1)
          l = src[0];
        else if (f == 2 && i == 2)
          l = src[4] ~^ m;
        else if (f == 2 && i == 3)
        begin
          d = 2;
          l = src[2] ~^ m;
        end
        else if (f == 2 && i == 4)
        begin
          d = src[6] ? 2 : 0;
          l = src[5];
        end
        else if (f == 2 && i == 5)
        begin
          d = (cfg[2][1:0] == 2 && src[8]) ? 2 : 0;
          l = src[7];
        end
        else if (i == 5 || f == 2)
          d = 2;
        e_oe[i] = (d == 1) || (d == 2 && !l);
        e_out[i] = (d == 1) && l;
      end
      prev[i] = a;
    end
    e_spe = (cfg[0][1:0] == 0) && (pin_in[0] === cfg[0][2]);
    e_twe = (cfg[2][1:0] == 2) && (cfg[2][5:4] == 2);
    e_tdin = pin_in[4];
    e_tcin = pin_in[5];
    e_rdata = (reg_addr >= 8'h1a && reg_addr <= 8'h1c) ? 8'(cfg[reg_addr - 8'h1a]) : 8'h00;
    if (reg_write && reg_addr >= 8'h1a && reg_addr <= 8'h1c)
      cfg[reg_addr - 8'h1a] = reg_wdata;
  endtask : predict

  // compare every result with the model
  task automatic compare();
    `CHK("reg_rdata", e_rdata, reg_rdata)
    `CHK("pin_supply_two", e_sup, pin_supply_two)
    `CHK("general_input", e_gin, general_input & e_gin_m)
    `CHK("debounce_enable", e_deb, debounce_enable)
    `CHK("wake_event", e_wake, wake_event)
    `CHK("pin_oe", e_oe, pin_oe)
    `CHK("pin_out", e_out, pin_out)
    `CHK("secondary_power_enable", e_spe, spe)
    `CHK("two_wire_enable", e_twe, twe)
    `CHK("two_wire_data_in", e_tdin, tdin)
    `CHK("two_wire_clock_in", e_tcin, tcin)
  endtask : compare

  ////////////////////////////////////////////////////////////////////////////////
  // one cycle of random traffic, driven at the falling edge
  task automatic step(input bit wr);
    int r;
    @(negedge sys_clk);
    compare();
    r = $random(seed);
    reg_write = wr && (r[1:0] == 2'h0);
    reg_addr = 8'h18 + 8'(r[4:2]);
    reg_wdata = 8'($random(seed));
    level_debounce = r[10:5];
    src = r[19:11];
    ext_drive = r[25:20];
    ext_level = 6'($random(seed));
    #1;
    predict();
  endtask : step

  // reset for 12 cycles, check reset values, release
  task automatic hold_reset();
    @(negedge sys_clk);
    reset = 1'b1;
    cfg = '{0, 0, 0};
    prev = '0;
    repeat (12) @(negedge sys_clk);
    {e_rdata, e_sup, e_deb, e_wake, e_oe, e_out, e_spe, e_twe, e_gin} = '0;
    {e_gin_m, e_tdin, e_tcin} = '1;
    compare();
    reset = 1'b0;
    #1;
    predict();
    $display("test reset done");
  endtask : hold_reset

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    hold_reset();
    repeat (3000) step(1'b1);
    $display("test random traffic done");
    repeat (200) step(1'b0);
    $display("test held config done");
    hold_reset();
    repeat (2000) step(1'b1);
    $display("test after second reset done");
    close_out();
  end

  // watchdog against a hang
  initial
  begin
    #(6000 * 40);
    errors++;
    close_out();
  end
endmodule : gpio_pin_config_10_to_15_bench

// ==== test/pin_world_model.sv ====
// far-side model: outside drivers and pull-ups on pins 10 to 15
module pin_world_model
#(
  parameter int PIN_COUNT = 6
)
(
  // device side of each pin
  input  wire logic [PIN_COUNT-1:0] pin_out,
  input  wire logic [PIN_COUNT-1:0] pin_oe,
  // outside parties
  input  wire logic [PIN_COUNT-1:0] ext_drive,
  input  wire logic [PIN_COUNT-1:0] ext_level,
  // resolved wire level
  output logic      [PIN_COUNT-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // device driver wins, then an outside driver, else the pull-up
  always_comb
  begin
    for (int i = 0; i < PIN_COUNT; i++)
      pin_level[i] = pin_oe[i] ? pin_out[i] : (ext_drive[i] ? ext_level[i] : 1'b1);
  end
endmodule : pin_world_model
